// *** gpd_pkg.sv ***
// Package of bus command codes and timing counts for the instrument bus interface.
package gpd_pkg;
   localparam logic [4:0] GPD_DEFAULT_ADDR = 5'h0b;
   localparam logic [6:0] GPD_CMD_GTL = 7'h01;
   localparam logic [6:0] GPD_CMD_SDC = 7'h04;
   localparam logic [6:0] GPD_CMD_PPC = 7'h05;
   localparam logic [6:0] GPD_CMD_GET = 7'h08;
   localparam logic [6:0] GPD_CMD_LLO = 7'h11;
   localparam logic [6:0] GPD_CMD_DCL = 7'h14;
   localparam logic [6:0] GPD_CMD_SPE = 7'h18;
   localparam logic [6:0] GPD_CMD_SPD = 7'h19;
   localparam logic [6:0] GPD_CMD_UNL = 7'h3f;
   localparam logic [6:0] GPD_CMD_UNT = 7'h5f;
   localparam logic [1:0] GPD_GRP_LISTEN = 2'h1;
   localparam logic [1:0] GPD_GRP_TALK = 2'h2;
   localparam int GPD_STB_RQS_BIT = 6;
   // Settle time between data placed on the bus and data valid asserted.
   localparam int GPD_SETTLE_NS = 10;
   localparam int GPD_CLK_NS = 5;
   localparam int GPD_SETTLE_CYC = (GPD_SETTLE_NS + GPD_CLK_NS - 1) / GPD_CLK_NS;
   typedef enum logic [1:0] {GPD_SH_IDLE, GPD_SH_SETTLE, GPD_SH_VALID, GPD_SH_WAIT} gpd_sh_state_t;
   typedef enum logic [1:0] {GPD_AH_READY, GPD_AH_ACCEPT, GPD_AH_WAIT} gpd_ah_state_t;
endpackage

// *** gpd_source_hs.sv ***
// Source handshake engine that drives one byte at a time onto the bus.
`timescale 1ns/1ps
`default_nettype none
module gpd_source_hs
   import gpd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic enable,
   input wire logic byte_valid,
   output logic byte_ready,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   output logic dav_out,
   output logic [7:0] dio_out,
   output logic eoi_out,
   output logic driving
);
   gpd_sh_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] data_reg;
   logic last_reg;
   // The settle counter below is four bits wide and must count at least once.
   if (GPD_SETTLE_CYC < 1 || GPD_SETTLE_CYC > 15) begin : g_settle_chk
      $error("settle count does not fit the source counter");
   end
   wire start = (state_reg == GPD_SH_IDLE) && enable && byte_valid;
   wire settled = (cnt_reg == 4'h0);
   assign byte_ready = (state_reg == GPD_SH_IDLE) && enable;
   assign dav_out = (state_reg == GPD_SH_VALID);
   assign dio_out = data_reg;
   assign eoi_out = last_reg && (state_reg != GPD_SH_IDLE);
   assign driving = (state_reg != GPD_SH_IDLE);
   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         state_reg <= GPD_SH_IDLE;
         cnt_reg <= 4'h0;
         data_reg <= 8'h00;
         last_reg <= 1'b0;
      end else begin
         case (state_reg)
            GPD_SH_IDLE: if (start) begin
               data_reg <= byte_data;
               last_reg <= byte_last;
               cnt_reg <= 4'(GPD_SETTLE_CYC);
               state_reg <= GPD_SH_SETTLE;
            end
            GPD_SH_SETTLE: begin
               if (!settled) cnt_reg <= cnt_reg - 4'h1;
               // Data valid only once ready-for-data and not-accepted are both seen.
               if (!enable) state_reg <= GPD_SH_IDLE;
               else if (settled && !nrfd_in && ndac_in) state_reg <= GPD_SH_VALID;
            end
            GPD_SH_VALID: begin
               // Attention takes the data lines back on the next clock, mid-handshake or not.
               if (!enable) state_reg <= GPD_SH_IDLE;
               else if (!ndac_in) state_reg <= GPD_SH_WAIT;
            end
            GPD_SH_WAIT: if (!enable || ndac_in) state_reg <= GPD_SH_IDLE;
            default: state_reg <= GPD_SH_IDLE;
         endcase
      end
   end
endmodule // gpd_source_hs
`default_nettype wire

// *** gpd_interface.sv ***
// Instrument-side bus interface: acceptor, talker, listener, service request, remote and clear.
// Functional notes
// - Source handshake moves talker bytes onto the bus.
// - Acceptor handshake holds ready and accepted so no byte is lost.
// - Device data is sent only while addressed as talker.
// - Basic talker with serial poll; own listen address drops talker state.
// - Device data is accepted only while addressed as listener.
// - Basic listener; own talk address drops listener state.
// - Device asks for service by asserting the service request line.
// - Remote is taken with remote enable asserted and own address received.
// - Go-to-local to an addressed listener returns the device to local.
// - No parallel poll response; data lines never answer a parallel poll.
// - Universal clear, or selective clear while addressed as listener, reinitialises the device.
// - Group trigger while addressed as listener starts the triggered operation.
// - No controller: attention, interface clear and remote enable never driven.
// - Only primary addresses are decoded; secondaries are ignored.
// - Serial poll enable plus talk returns status; disable ends it.
// - Primary address defaults to eleven unless reconfigured.
// - Attention asserted means command bytes, released means device data.
// - Data valid follows ready and not-accepted, drops after accepted, per byte.
// - Interface clear idles talker and listener but keeps remote.
// - End-or-identify goes out with the final byte of a transfer.
`timescale 1ns/1ps
`default_nettype none
module gpd_interface
   import gpd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] cfg_addr,
   input wire logic cfg_addr_load,
   input wire logic atn_in,
   input wire logic ifc_in,
   input wire logic ren_in,
   input wire logic [7:0] dio_in,
   input wire logic dav_in,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   input wire logic eoi_in,
   output logic [7:0] dio_out,
   output logic dio_oe,
   output logic dav_out,
   output logic dav_oe,
   output logic nrfd_out,
   output logic nrfd_oe,
   output logic ndac_out,
   output logic ndac_oe,
   output logic eoi_out,
   output logic eoi_oe,
   output logic srq_out,
   output logic srq_oe,
   output logic atn_out,
   output logic atn_oe,
   output logic ifc_out,
   output logic ifc_oe,
   output logic ren_out,
   output logic ren_oe,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_valid,
   input wire logic [7:0] status_byte,
   input wire logic service_req,
   output logic talker_active,
   output logic listener_active,
   output logic serial_poll,
   output logic remote,
   output logic trigger,
   output logic device_clear
);
   logic [4:0] addr_reg;
   logic talk_reg;
   logic listen_reg;
   logic spoll_reg;
   logic remote_reg;
   gpd_ah_state_t ah_reg;
   logic [7:0] rx_data_reg;
   logic rx_last_reg;
   logic rx_valid_reg;
   logic trig_reg;
   logic clr_reg;
   logic stb_sent_reg;
   // True when a command byte carries the given address group and this device's address.
   function automatic logic gpd_addr_hit(input logic [6:0] c, input logic [1:0] grp,
      input logic [4:0] own);
      return (c[6:5] == grp) && (c[4:0] == own);
   endfunction
   // Bus lines are low true; inputs here are already logic-true levels.
   // Interface clear wins over a byte in flight, so nothing is taken while it stands.
   wire accept = (ah_reg == GPD_AH_READY) && dav_in && !ifc_in;
   wire [6:0] cmd = dio_in[6:0];
   wire cmd_accept = accept && atn_in;
   wire data_accept = accept && !atn_in && listen_reg;
   wire is_mla = gpd_addr_hit(cmd, GPD_GRP_LISTEN, addr_reg);
   wire is_mta = gpd_addr_hit(cmd, GPD_GRP_TALK, addr_reg);
   wire is_ota = cmd[6:5] == GPD_GRP_TALK && !is_mta && cmd != GPD_CMD_UNT;
   wire is_unl = cmd == GPD_CMD_UNL;
   wire is_unt = cmd == GPD_CMD_UNT;
   wire is_dcl = cmd == GPD_CMD_DCL;
   wire is_sdc = cmd == GPD_CMD_SDC && listen_reg;
   wire is_gtl = cmd == GPD_CMD_GTL && listen_reg;
   wire is_get = cmd == GPD_CMD_GET && listen_reg;
   wire is_spe = cmd == GPD_CMD_SPE;
   wire is_spd = cmd == GPD_CMD_SPD;
   wire do_clear = cmd_accept && (is_dcl || is_sdc);
   // The talker may source only with attention released.
   wire sh_enable = talk_reg && !atn_in && !ifc_in;
   wire src_valid = spoll_reg ? !stb_sent_reg : tx_valid;
   wire [7:0] src_data = spoll_reg
      ? {status_byte[7], service_req, status_byte[5:0]} : tx_data;
   wire src_last = spoll_reg ? 1'b0 : tx_last;
   wire src_ready;
   wire sh_driving;
   wire [7:0] sh_dio;
   wire sh_eoi;
   wire sh_dav;
   gpd_source_hs u_src (
      .clk(clk),
      .rst_n(rst_n),
      .clear(ifc_in),
      .enable(sh_enable),
      .byte_valid(src_valid),
      .byte_ready(src_ready),
      .byte_data(src_data),
      .byte_last(src_last),
      .nrfd_in(nrfd_in),
      .ndac_in(ndac_in),
      .dav_out(sh_dav),
      .dio_out(sh_dio),
      .eoi_out(sh_eoi),
      .driving(sh_driving)
   );
   assign tx_ready = src_ready && !spoll_reg;
   // Parallel poll (attention with end-or-identify) is never answered on the data lines.
   assign dio_out = sh_dio;
   assign dio_oe = sh_driving && talk_reg;
   assign dav_out = sh_dav;
   assign dav_oe = sh_driving && talk_reg;
   assign eoi_out = sh_eoi;
   assign eoi_oe = sh_driving && talk_reg;
   // Acceptor: not-ready held while a byte is in hand, not-accepted until it is taken.
   wire ah_idle = ifc_in ? 1'b1 : !(atn_in || listen_reg);
   assign nrfd_out = !ah_idle && (ah_reg != GPD_AH_READY);
   assign nrfd_oe = nrfd_out;
   assign ndac_out = !ah_idle && (ah_reg != GPD_AH_WAIT);
   assign ndac_oe = ndac_out;
   assign srq_out = service_req && !spoll_reg;
   assign srq_oe = srq_out;
   assign atn_out = 1'b0;
   assign atn_oe = 1'b0;
   assign ifc_out = 1'b0;
   assign ifc_oe = 1'b0;
   assign ren_out = 1'b0;
   assign ren_oe = 1'b0;
   assign rx_data = rx_data_reg;
   assign rx_last = rx_last_reg;
   assign rx_valid = rx_valid_reg;
   assign talker_active = talk_reg;
   assign listener_active = listen_reg;
   assign serial_poll = spoll_reg;
   assign remote = remote_reg;
   assign trigger = trig_reg;
   assign device_clear = clr_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_reg <= GPD_DEFAULT_ADDR;
      end else if (cfg_addr_load) begin
         addr_reg <= cfg_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ah_reg <= GPD_AH_READY;
      end else if (ah_idle) begin
         ah_reg <= GPD_AH_READY;
      end else begin
         case (ah_reg)
            GPD_AH_READY: if (dav_in) ah_reg <= GPD_AH_ACCEPT;
            GPD_AH_ACCEPT: ah_reg <= GPD_AH_WAIT;
            GPD_AH_WAIT: if (!dav_in) ah_reg <= GPD_AH_READY;
            default: ah_reg <= GPD_AH_READY;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || ifc_in) begin
         talk_reg <= 1'b0;
         listen_reg <= 1'b0;
      end else if (cmd_accept) begin
         if (is_mta) talk_reg <= 1'b1;
         else if (is_unt || is_ota || is_mla) talk_reg <= 1'b0;
         if (is_mla) listen_reg <= 1'b1;
         else if (is_unl || is_mta) listen_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || ifc_in) begin
         spoll_reg <= 1'b0;
      end else if (cmd_accept && is_spe) begin
         spoll_reg <= 1'b1;
      end else if (cmd_accept && is_spd) begin
         spoll_reg <= 1'b0;
      end
   end

   // One status byte per talk handshake; a new attention cycle rearms it.
   always_ff @(posedge clk) begin
      if (!rst_n || atn_in || !spoll_reg) begin
         stb_sent_reg <= 1'b0;
      end else if (src_ready && src_valid) begin
         stb_sent_reg <= 1'b1;
      end
   end

   // Remote survives interface clear; only remote enable or go-to-local end it.
   always_ff @(posedge clk) begin
      if (!rst_n || !ren_in) begin
         remote_reg <= 1'b0;
      end else if (cmd_accept && is_gtl) begin
         remote_reg <= 1'b0;
      end else if (cmd_accept && (is_mla || is_mta)) begin
         remote_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trig_reg <= 1'b0;
         clr_reg <= 1'b0;
      end else begin
         trig_reg <= cmd_accept && is_get;
         clr_reg <= do_clear;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_valid_reg <= 1'b0;
         rx_data_reg <= 8'h00;
         rx_last_reg <= 1'b0;
      end else begin
         rx_valid_reg <= data_accept;
         if (data_accept) begin
            rx_data_reg <= dio_in;
            rx_last_reg <= eoi_in;
         end
      end
   end
endmodule // gpd_interface
`default_nettype wire

// *** gpd_interface_chk.sv ***
// Checker of bus-side relations of the instrument bus interface.
`timescale 1ns/1ps
`default_nettype none
module gpd_interface_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic atn_in,
   input wire logic ifc_in,
   input wire logic dav_in,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   input wire logic nrfd_out,
   input wire logic ndac_out,
   input wire logic dio_oe,
   input wire logic dav_out,
   input wire logic atn_oe,
   input wire logic ifc_oe,
   input wire logic ren_oe,
   input wire logic srq_out,
   input wire logic service_req,
   input wire logic serial_poll,
   input wire logic talker_active,
   input wire logic listener_active,
   input wire logic trigger,
   input wire logic rx_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   no_control_a: assert property (!atn_oe && !ifc_oe && !ren_oe)
      else $error("controller line driven");
   dav_gate_a: assert property ($rose(dav_out) |-> !nrfd_in && ndac_in)
      else $error("data valid raised early");
   dav_drop_a: assert property (dav_out && !ndac_in |-> ##[1:2] !dav_out)
      else $error("data valid held after accept");
   talk_only_a: assert property (dio_oe |-> talker_active && !$past(atn_in))
      else $error("data lines driven unaddressed");
   dav_release_a: assert property (dav_out |-> dio_oe)
      else $error("data valid without data");
   srq_drive_a: assert property ((service_req && !serial_poll) [*2] |-> srq_out)
      else $error("service request missing");
   trig_pulse_a: assert property (trigger |=> !trigger)
      else $error("trigger pulse too long");
   ifc_idle_a: assert property (ifc_in |=> !talker_active && !listener_active)
      else $error("interface clear ignored");
   rx_listen_a: assert property (rx_valid |-> listener_active)
      else $error("data taken unaddressed");
   cmd_accept_a: assert property (dav_in && atn_in && !nrfd_out && ndac_out |=> nrfd_out)
      else $error("command byte not held");
   cover property ($rose(dav_out));
   cover property (serial_poll && dav_out);
   cover property (trigger);
   cover property (rx_valid);
endmodule // gpd_interface_chk
bind gpd_interface gpd_interface_chk u_gpd_interface_chk (.*);
`default_nettype wire

// *** gpd_ctl_model.sv ***
// Bus controller model: sources commands and data, and accepts talker bytes.
`timescale 1ns/1ps
`default_nettype none
module gpd_ctl_model (
   input wire logic clk,
   input wire logic stall,
   input wire logic dav_in,
   input wire logic [7:0] dio_in,
   input wire logic eoi_in,
   input wire logic nrfd_in,
   input wire logic ndac_in,
   output logic atn_in = 1'b0,
   output logic ifc_in = 1'b0,
   output logic ren_in = 1'b0,
   output logic [7:0] c_dio = 8'h00,
   output logic c_dav = 1'b0,
   output logic c_eoi = 1'b0,
   output logic p_nrfd,
   output logic p_ndac,
   output logic [7:0] got = 8'h00,
   output logic got_eoi = 1'b0
);
   logic acc = 1'b0;
   assign p_nrfd = stall | acc;
   assign p_ndac = !acc;
   always @(posedge clk) begin
      if (dav_in && !acc && !stall) begin
         got <= dio_in;
         got_eoi <= eoi_in;
         acc <= 1'b1;
      end else if (!dav_in) begin
         acc <= 1'b0;
      end
   end
   task automatic lines(input logic a, input logic i, input logic r);
      atn_in <= a;
      ifc_in <= i;
      ren_in <= r;
      @(posedge clk);
   endtask
   // Released data lines fall back to the pulled-up false level.
   task automatic put(input logic a, input logic [7:0] d, input logic e);
      int i;
      atn_in <= a;
      c_dio <= d;
      c_eoi <= e;
      @(posedge clk);
      for (i = 0; i < 100 && !(nrfd_in === 1'b0 && ndac_in === 1'b1); i++) @(posedge clk);
      c_dav <= 1'b1;
      for (i = 0; i < 100 && ndac_in !== 1'b0; i++) @(posedge clk);
      if (ndac_in === 1'b0) @(posedge clk);
      c_dav <= 1'b0;
      c_dio <= 8'h00;
      c_eoi <= 1'b0;
      @(posedge clk);
      @(posedge clk);
   endtask
endmodule // gpd_ctl_model
`default_nettype wire

// *** gpd_interface_tb.sv ***
// Self-checking testbench of the instrument bus interface.
`timescale 1ns/1ps
`default_nettype none
module gpd_interface_tb;
   import gpd_pkg::*;
   typedef struct {logic [7:0] b; logic t; logic l;} gpd_row_t;
   logic clk, rst_n, cfg_addr_load, atn_in, ifc_in, ren_in, dav_in, nrfd_in, ndac_in, eoi_in;
   logic [4:0] cfg_addr;
   logic [7:0] dio_in, dio_out, tx_data, rx_data, status_byte, c_dio, got, rx_d;
   logic dio_oe, dav_out, dav_oe, nrfd_out, nrfd_oe, ndac_out, ndac_oe, eoi_out, eoi_oe;
   logic srq_out, srq_oe, atn_out, atn_oe, ifc_out, ifc_oe, ren_out, ren_oe;
   logic tx_valid, tx_ready, tx_last, rx_last, rx_valid, service_req, talker_active;
   logic listener_active, serial_poll, remote, trigger, device_clear;
   logic stall, c_dav, c_eoi, p_nrfd, p_ndac, got_eoi, rx_l;
   int num_errors = 0, n_compared = 0, n_trg = 0, n_clr = 0;
   gpd_row_t rows[11] = '{'{8'h2b, 1'b0, 1'b1}, '{8'h4b, 1'b1, 1'b0}, '{8'h2b, 1'b0, 1'b1},
      '{8'h3f, 1'b0, 1'b0}, '{8'h4b, 1'b1, 1'b0}, '{8'h5f, 1'b0, 1'b0},
      '{8'h05, 1'b0, 1'b0}, '{8'h4b, 1'b1, 1'b0}, '{8'h4c, 1'b0, 1'b0},
      '{8'h2b, 1'b0, 1'b1}, '{8'h6b, 1'b0, 1'b1}};
   assign dio_in = c_dio | (dio_oe ? dio_out : 8'h00);
   assign dav_in = c_dav | (dav_oe & dav_out);
   assign eoi_in = c_eoi | (eoi_oe & eoi_out);
   assign nrfd_in = p_nrfd | (nrfd_oe & nrfd_out);
   assign ndac_in = p_ndac | (ndac_oe & ndac_out);
   gpd_interface u_gpd_interface (.*);
   gpd_ctl_model u_gpd_ctl_model (.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         rx_d <= rx_data;
         rx_l <= rx_last;
      end
      if (trigger === 1'b1) n_trg++;
      if (device_clear === 1'b1) n_clr++;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tx(input logic [7:0] d, input logic l);
      int i;
      tx_data <= d;
      tx_last <= l;
      tx_valid <= 1'b1;
      i = 0;
      do @(posedge clk); while (tx_ready !== 1'b1 && ++i < 200);
      if (l) tx_valid <= 1'b0;
   endtask
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #50000;
      num_errors++;
      summarize();
   end
   initial begin
      {rst_n, cfg_addr_load, tx_valid, tx_last, service_req, stall} <= 6'h00;
      {cfg_addr, tx_data, status_byte} <= 21'h000000;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      u_gpd_ctl_model.lines(1'b1, 1'b0, 1'b1);
      foreach (rows[k]) begin
         u_gpd_ctl_model.put(1'b1, rows[k].b, 1'b0);
         chk1(talker_active, rows[k].t);
         chk1(listener_active, rows[k].l);
      end
      chk1(remote, 1'b1);
      u_gpd_ctl_model.put(1'b1, 8'h2b, 1'b0);
      u_gpd_ctl_model.put(1'b0, 8'ha5, 1'b1);
      chk(rx_d, 8'ha5);
      chk1(rx_l, 1'b1);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_GET}, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_DCL}, 1'b0);
      u_gpd_ctl_model.put(1'b1, 8'h2b, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_SDC}, 1'b0);
      u_gpd_ctl_model.put(1'b1, 8'h2b, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_GTL}, 1'b0);
      chk(8'(n_trg), 8'h01);
      chk(8'(n_clr), 8'h02);
      chk1(remote, 1'b0);
      u_gpd_ctl_model.put(1'b1, 8'h4b, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_GET}, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_SDC}, 1'b0);
      stall <= 1'b1;
      u_gpd_ctl_model.lines(1'b0, 1'b0, 1'b1);
      tx(8'h31, 1'b0);
      repeat (10) @(posedge clk);
      chk1(dav_out, 1'b0);
      stall <= 1'b0;
      tx(8'h32, 1'b1);
      chk(got, 8'h31);
      chk1(got_eoi, 1'b0);
      repeat (40) @(posedge clk);
      chk(got, 8'h32);
      chk1(got_eoi, 1'b1);
      chk(8'(n_trg), 8'h01);
      chk(8'(n_clr), 8'h02);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_SPE}, 1'b0);
      u_gpd_ctl_model.put(1'b1, 8'h4b, 1'b0);
      service_req <= 1'b1;
      status_byte <= 8'h01;
      u_gpd_ctl_model.lines(1'b0, 1'b0, 1'b1);
      repeat (40) @(posedge clk);
      chk(got, 8'h41);
      chk1(srq_out, 1'b0);
      u_gpd_ctl_model.put(1'b1, {1'b0, GPD_CMD_SPD}, 1'b0);
      chk1(serial_poll, 1'b0);
      chk1(srq_out, 1'b1);
      u_gpd_ctl_model.lines(1'b1, 1'b1, 1'b1);
      u_gpd_ctl_model.lines(1'b1, 1'b0, 1'b1);
      chk1(talker_active, 1'b0);
      chk1(remote, 1'b1);
      cfg_addr <= 5'h05;
      cfg_addr_load <= 1'b1;
      @(posedge clk);
      cfg_addr_load <= 1'b0;
      u_gpd_ctl_model.put(1'b1, 8'h25, 1'b0);
      chk1(listener_active, 1'b1);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk1(listener_active, 1'b0);
      u_gpd_ctl_model.put(1'b1, 8'h2b, 1'b0);
      chk1(listener_active, 1'b1);
      summarize();
   end
endmodule // gpd_interface_tb
`default_nettype wire
